/* hw/fmlkd_pkg.sv */
// Purpose: Shared constants for the modulator and lock-detect register bank
// Assumes: 24-bit register words, 6-bit register addresses
// Notes:
// Operation
// - In fractional mode the seed register is the modulator starting state.
// - With FSK enabled the seed register holds the first FSK frequency.
// - Type field bits 9:8, default 2; 2 selects type 1, 3 type 2.
// - Core reset bit 10, active low, default 1, holds modulator core reset.
// - Buffer reset bit 11, active low, default 1, holds core buffers reset.
// - Bypass bit 12 ignores modulator output while the modulator keeps clocking.
// - Auto-seed bit 13, default 1, reloads seed on each fraction write while FSK is off.
// - Bit 15 enables FSK and accepts the FSK control level on SDI.
// - Bit 17 selects modulator clock: 1 reference divider, 0 VCO divider.
// - Bit 18, default 1, inverts the selected modulator clock.
// - Bits 23:20, default 8, set slip-correction magnitude; sign chosen internally.
// - Lock declared once consecutive in-window VCO events reach count field 9:0.
// - Lock register bit 10, default 1, enables internal lock detection.
// - Bit 11 makes the window one-sided; bit 12 picks lead, else lag.
// - Bit 13 selects ring-oscillator one-shot, else nominal 20 ns one-shot.
// - Bits 16:14 set the ring-oscillator one-shot length.
// - Bits 18:17 trim ring oscillator speed, 00 fastest, 11 slowest.
// - Lock register bit 20, default 1, enables cycle slip prevention.
// - Writing bit 0 at address zero resets all logic and registers.

package fmlkd_pkg;

  // ----------------------------------------
  // Register addresses and reset values
  // ----------------------------------------
  localparam logic [5:0]  ADDR_ID   = 6'h00;
  localparam logic [5:0]  ADDR_FRAC = 6'h04;
  localparam logic [5:0]  ADDR_SEED = 6'h05;
  localparam logic [5:0]  ADDR_CFG  = 6'h06;
  localparam logic [5:0]  ADDR_LKD  = 6'h07;
  localparam logic [23:0] SEED_RST  = 24'h000000;
  localparam logic [23:0] CFG_RST   = 24'h842E87;
  localparam logic [20:0] LKD_RST   = 21'h1004FA;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SWRST_BIT    = 0;
  localparam int CFG_ORDER    = 8;
  localparam int CFG_CORE_RN  = 10;
  localparam int CFG_BUF_RN   = 11;
  localparam int CFG_BYPASS   = 12;
  localparam int CFG_AUTOSEED = 13;
  localparam int CFG_FSK      = 15;
  localparam int CFG_REF_SEL  = 17;
  localparam int CFG_INVERT   = 18;
  localparam int CFG_CSP_MAG  = 20;
  localparam int LKD_WINCNT   = 0;
  localparam int LKD_EN       = 10;
  localparam int LKD_ASYM     = 11;
  localparam int LKD_LEAD     = 12;
  localparam int LKD_RO_SEL   = 13;
  localparam int LKD_DUR      = 14;
  localparam int LKD_TRIM     = 17;
  localparam int LKD_RO_FORCE = 19;
  localparam int LKD_CSP_EN   = 20;

  // Modulator type code that selects the second type
  localparam logic [1:0] ORDER_TYPE2 = 2'h3;

  // ----------------------------------------
  // Serial frame edge counts (zero based)
  // ----------------------------------------
  localparam logic [5:0] EDGE_ADDR_END = 6'h06;
  localparam logic [5:0] EDGE_DATA_END = 6'h1E;
  localparam logic [5:0] EDGE_LAST     = 6'h1F;

endpackage

/* hw/fmlkd_lock_counter.sv */
// Purpose: Counts consecutive divided-VCO events inside the lock window
// Assumes: One-cycle event pulse with its window verdict on the same cycle
// Notes: Count saturates at the threshold so a long lock never wraps
`timescale 1ns/1ps

module fmlkd_lock_counter
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       enable,
  input  wire logic [9:0] winCntMax,
  // Events
  input  wire logic       vcoEvent,
  input  wire logic       inWindow,
  // Status
  output logic            locked
);

  logic [9:0] winCnt;
  logic [9:0] next_winCnt;
  logic       reach;

  assign next_winCnt = (winCnt >= winCntMax) ? winCnt : winCnt + 10'h001;
  assign reach       = (next_winCnt >= winCntMax);

  always_ff @(posedge clk)
  begin
    if (srst || !enable)
    begin
      winCnt <= 10'h000;
      locked <= 1'b0;
    end
    else if (vcoEvent && inWindow)
    begin
      winCnt <= next_winCnt;
      locked <= locked | reach;
    end
    else if (vcoEvent)
    begin
      winCnt <= 10'h000;
      locked <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  lock_reach_a: assert property (enable && vcoEvent && inWindow && reach |=> locked)
    else $error("lock not declared at threshold");
  lock_early_a: assert property (!$past(locked) && locked |-> winCnt >= winCntMax)
    else $error("lock declared below threshold");
  miss_clear_a: assert property (enable && vcoEvent && !inWindow |=> !locked && winCnt == 0)
    else $error("out-of-window event kept lock");
  lock_off_a: assert property (!enable |=> !locked)
    else $error("lock held while detection disabled");

endmodule

/* hw/fmlkd_serial_port.sv */
// Purpose: Serial register port: 1 read bit, 6 address bits, 24 data bits
// Assumes: SCK high and low phases each last at least 3 clk periods
// Notes: Pins are sampled on clk, so data leaves one sync delay late
`timescale 1ns/1ps

module fmlkd_serial_port
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Pins
  input  wire logic        senPin,
  input  wire logic        sckPin,
  input  wire logic        sdiPin,
  // Synchronised pin levels
  output logic             senLevel,
  output logic             sdiLevel,
  // Read side
  output logic [5:0]       rdAddr,
  input  wire logic [23:0] rdData,
  output logic             rdActive,
  output logic             sdoBit,
  // Write side
  output logic             wrStb,
  output logic [5:0]       wrAddr,
  output logic [23:0]      wrData
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0]  pinMeta;
  logic [2:0]  pinSync;
  logic        sckPrev;
  logic        sckRise;
  logic [5:0]  edgeCnt;
  logic [29:0] shiftIn;
  logic [23:0] outShift;
  logic        isRead;
  logic        loadPend;

  localparam logic [5:0] EDGE_ADDR_END = fmlkd_pkg::EDGE_ADDR_END;
  localparam logic [5:0] EDGE_DATA_END = fmlkd_pkg::EDGE_DATA_END;
  localparam logic [5:0] EDGE_LAST     = fmlkd_pkg::EDGE_LAST;

  always_ff @(posedge clk)
  begin
    pinMeta <= {senPin, sckPin, sdiPin};
    pinSync <= pinMeta;
    sckPrev <= pinSync[1];
  end

  assign senLevel = pinSync[2];
  assign sdiLevel = pinSync[0];
  assign sckRise  = pinSync[2] & pinSync[1] & ~sckPrev;

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    wrStb <= 1'b0;
    if (srst || !senLevel)
    begin
      edgeCnt  <= 6'h00;
      rdActive <= 1'b0;
      loadPend <= 1'b0;
      isRead   <= 1'b0;
    end
    else if (loadPend)
    begin
      outShift <= rdData;
      loadPend <= 1'b0;
    end
    else if (sckRise)
    begin
      edgeCnt <= edgeCnt + 6'h01;
      shiftIn <= {shiftIn[28:0], sdiLevel};
      if (edgeCnt == 6'h00)
        isRead <= sdiLevel;
      if (edgeCnt == EDGE_ADDR_END)
      begin
        rdAddr   <= {shiftIn[4:0], sdiLevel};
        rdActive <= isRead;
        loadPend <= isRead;
      end
      if (rdActive && edgeCnt > EDGE_ADDR_END && edgeCnt < EDGE_LAST)
      begin
        sdoBit   <= outShift[23];
        outShift <= {outShift[22:0], 1'b0};
      end
      if (edgeCnt == EDGE_LAST)
        rdActive <= 1'b0;
      if (edgeCnt == EDGE_DATA_END && !isRead)
      begin
        wrStb  <= 1'b1;
        wrAddr <= shiftIn[28:23];
        wrData <= {shiftIn[22:0], sdiLevel};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence addr_done_s;
    sckRise && edgeCnt == EDGE_ADDR_END && isRead;
  endsequence
  sequence read_open_s;
    rdActive ##1 loadPend == 1'b0;
  endsequence

  read_start_a: assert property (addr_done_s |=> read_open_s)
    else $error("read frame did not open readback");
  write_once_a: assert property (wrStb |=> !wrStb)
    else $error("write strobe longer than one cycle");

endmodule

/* hw/fmlkd_top.sv */
// Purpose: Modulator configuration, FSK routing and lock-detect control
// Assumes: Divider clocks and window hits are asynchronous pins
// Notes: All register state returns to defaults on srst or soft reset
`timescale 1ns/1ps

module fmlkd_top #(
  // Arbitrary identification value
  parameter logic [23:0] CHIP_ID = 24'h5A3C00
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Serial port pins
  input  wire logic        senPin,
  input  wire logic        sckPin,
  input  wire logic        sdiPin,
  output logic             lockOrReadbackPin,
  // Lock flag output gate, an external input rather than a register bit
  input  wire logic        lockFlagOutputGate,
  // Divided clocks and window hits
  input  wire logic        refDivClk,
  input  wire logic        vcoDivClk,
  input  wire logic        winLeadHit,
  input  wire logic        winLagHit,
  // Modulator control
  output logic [23:0]      modSeed,
  output logic [23:0]      fskFreq1,
  output logic             seedLoad,
  output logic             fskMode,
  output logic             fskSelect,
  output logic             modTypeSel,
  output logic             coreRstN,
  output logic             bufRstN,
  output logic             modBypass,
  output logic             modClk,
  // Slip prevention and one-shot control
  output logic [3:0]       cspMagnitude,
  output logic             cspEnable,
  output logic             ringOscOneshotSel,
  output logic [2:0]       oneshotDuration,
  output logic [1:0]       ringOscTrim,
  output logic             ringOscForce,
  // Lock status
  output logic             lockDetected
);

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic        senLevel;
  logic        sdiLevel;
  logic        rdActive;
  logic        sdoBit;
  logic        wrStb;
  logic [5:0]  rdAddr;
  logic [5:0]  wrAddr;
  logic [23:0] wrData;
  logic [23:0] rdData;

  fmlkd_serial_port u_port (
    .clk      (clk),
    .srst     (srst),
    .senPin   (senPin),
    .sckPin   (sckPin),
    .sdiPin   (sdiPin),
    .senLevel (senLevel),
    .sdiLevel (sdiLevel),
    .rdAddr   (rdAddr),
    .rdData   (rdData),
    .rdActive (rdActive),
    .sdoBit   (sdoBit),
    .wrStb    (wrStb),
    .wrAddr   (wrAddr),
    .wrData   (wrData)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic wrId;
  logic wrFrac;
  logic wrSeed;
  logic wrCfg;
  logic wrLkd;
  logic softRst;
  logic regRst;

  assign wrId    = wrStb & (wrAddr == fmlkd_pkg::ADDR_ID);
  assign wrFrac  = wrStb & (wrAddr == fmlkd_pkg::ADDR_FRAC);
  assign wrSeed  = wrStb & (wrAddr == fmlkd_pkg::ADDR_SEED);
  assign wrCfg   = wrStb & (wrAddr == fmlkd_pkg::ADDR_CFG);
  assign wrLkd   = wrStb & (wrAddr == fmlkd_pkg::ADDR_LKD);
  assign softRst = wrId & wrData[fmlkd_pkg::SWRST_BIT];
  assign regRst  = srst | softRst;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [23:0] seedReg;
  logic [23:0] cfgReg;
  logic [20:0] lkdReg;

  always_ff @(posedge clk)
  begin
    if (regRst)
    begin
      seedReg <= fmlkd_pkg::SEED_RST;
      cfgReg  <= fmlkd_pkg::CFG_RST;
      lkdReg  <= fmlkd_pkg::LKD_RST;
    end
    else
    begin
      if (wrSeed)
        seedReg <= wrData;
      if (wrCfg)
        cfgReg <= wrData;
      if (wrLkd)
        lkdReg <= wrData[20:0];
    end
  end

  // Readback; the fraction register lives elsewhere and reads as zero here
  assign rdData = (rdAddr == fmlkd_pkg::ADDR_ID)   ? CHIP_ID :
                  (rdAddr == fmlkd_pkg::ADDR_SEED) ? seedReg :
                  (rdAddr == fmlkd_pkg::ADDR_CFG)  ? cfgReg  :
                  (rdAddr == fmlkd_pkg::ADDR_LKD)  ? {3'h0, lkdReg} :
                  24'h000000;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  logic       fskOn;
  logic       reloadOnFractionWrite;
  logic       coreRunBit;
  logic       asymWin;
  logic       leadWin;
  logic       lkdOn;
  logic [9:0] winCntMax;
  logic [1:0] orderCode;

  assign fskOn      = cfgReg[fmlkd_pkg::CFG_FSK];
  assign reloadOnFractionWrite = cfgReg[fmlkd_pkg::CFG_AUTOSEED];
  assign coreRunBit = cfgReg[fmlkd_pkg::CFG_CORE_RN];
  assign orderCode  = cfgReg[fmlkd_pkg::CFG_ORDER +: 2];
  assign asymWin    = lkdReg[fmlkd_pkg::LKD_ASYM];
  assign leadWin    = lkdReg[fmlkd_pkg::LKD_LEAD];
  assign lkdOn      = lkdReg[fmlkd_pkg::LKD_EN];
  assign winCntMax  = lkdReg[fmlkd_pkg::LKD_WINCNT +: 10];

  // ----------------------------------------
  // Analog input synchronisers
  // ----------------------------------------
  // Order: 3 ref divider, 2 VCO divider, 1 lead hit, 0 lag hit
  logic [3:0] anaMeta;
  logic [3:0] anaSync;
  logic       vcoPrev;
  logic       vcoEvent;
  logic       inWindow;

  always_ff @(posedge clk)
  begin
    anaMeta <= {refDivClk, vcoDivClk, winLeadHit, winLagHit};
    anaSync <= anaMeta;
    vcoPrev <= anaSync[2];
  end

  // Hits travel through the same depth as the VCO edge, so they stay aligned
  assign vcoEvent = anaSync[2] & ~vcoPrev;
  assign inWindow = asymWin ? (leadWin ? anaSync[1] : anaSync[0])
                            : (anaSync[1] | anaSync[0]);

  // ----------------------------------------
  // Lock detection
  // ----------------------------------------
  logic locked;

  fmlkd_lock_counter u_lock (
    .clk       (clk),
    .srst      (regRst),
    .enable    (lkdOn),
    .winCntMax (winCntMax),
    .vcoEvent  (vcoEvent),
    .inWindow  (inWindow),
    .locked    (locked)
  );

  // ----------------------------------------
  // Modulator control next values
  // ----------------------------------------
  logic next_seedLoad;
  logic next_fskSelect;
  logic selClk;
  logic next_pin;

  // With FSK off, seed loads on a fraction write with auto-seed set or when the core leaves reset
  assign next_seedLoad  = ~fskOn & ((wrFrac & reloadOnFractionWrite)
                                    | (coreRunBit & ~coreRstN));
  // SDI carries FSK only while no serial frame is open
  assign next_fskSelect = fskOn & (senLevel ? fskSelect : sdiLevel);
  assign selClk         = cfgReg[fmlkd_pkg::CFG_REF_SEL] ? anaSync[3] : anaSync[2];
  assign next_pin       = rdActive ? sdoBit : (lockFlagOutputGate & locked);

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (regRst)
    begin
      seedLoad  <= 1'b0;
      fskSelect <= 1'b0;
      coreRstN  <= 1'b1;
    end
    else
    begin
      seedLoad  <= next_seedLoad;
      fskSelect <= next_fskSelect;
      coreRstN  <= coreRunBit;
    end
  end

  always_ff @(posedge clk)
  begin
    modSeed           <= fskOn ? 24'h000000 : seedReg;
    fskFreq1          <= fskOn ? seedReg : 24'h000000;
    fskMode           <= fskOn;
    modTypeSel        <= (orderCode == fmlkd_pkg::ORDER_TYPE2);
    bufRstN           <= cfgReg[fmlkd_pkg::CFG_BUF_RN];
    modBypass         <= cfgReg[fmlkd_pkg::CFG_BYPASS];
    modClk            <= selClk ^ cfgReg[fmlkd_pkg::CFG_INVERT];
    cspMagnitude      <= cfgReg[fmlkd_pkg::CFG_CSP_MAG +: 4];
    cspEnable         <= lkdReg[fmlkd_pkg::LKD_CSP_EN];
    ringOscOneshotSel <= lkdReg[fmlkd_pkg::LKD_RO_SEL];
    oneshotDuration   <= lkdReg[fmlkd_pkg::LKD_DUR +: 3];
    ringOscTrim       <= lkdReg[fmlkd_pkg::LKD_TRIM +: 2];
    ringOscForce      <= lkdReg[fmlkd_pkg::LKD_RO_FORCE];
    lockDetected      <= locked;
    lockOrReadbackPin <= next_pin;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  soft_reset_a: assert property (softRst |=> cfgReg == fmlkd_pkg::CFG_RST
      && lkdReg == fmlkd_pkg::LKD_RST && seedReg == fmlkd_pkg::SEED_RST)
    else $error("soft reset left a register changed");
  auto_seed_a: assert property (wrFrac && reloadOnFractionWrite && !fskOn |=> seedLoad)
    else $error("fraction write did not reload seed");
  no_seed_a: assert property (wrFrac && !reloadOnFractionWrite && coreRstN
      && !softRst |=> !seedLoad)
    else $error("seed reloaded with auto-seed off");
  core_hold_a: assert property (!coreRunBit ##1 !coreRunBit |-> !coreRstN)
    else $error("core left reset while bit clear");
  fsk_route_a: assert property (fskOn && !softRst |=> fskFreq1 == $past(seedReg)
      && modSeed == 24'h000000)
    else $error("seed not routed to FSK frequency");
  win_sel_a: assert property (asymWin && leadWin |-> inWindow == anaSync[1])
    else $error("lead window not selected");
  mod_clk_a: assert property (##1 modClk == ($past(selClk) ^
      $past(cfgReg[fmlkd_pkg::CFG_INVERT])))
    else $error("modulator clock source or polarity wrong");
  bypass_clk_a: assert property (modBypass && !cfgReg[fmlkd_pkg::CFG_REF_SEL]
      && $rose(anaSync[2]) && !cfgReg[fmlkd_pkg::CFG_INVERT] |=> modClk)
    else $error("modulator stopped under bypass");
  pin_lock_a: assert property (!rdActive && lockFlagOutputGate |=>
      lockOrReadbackPin == $past(locked))
    else $error("lock flag not presented on pin");
  type_sel_a: assert property (##1 modTypeSel ==
      ($past(orderCode) == fmlkd_pkg::ORDER_TYPE2))
    else $error("modulator type select wrong");
  buf_rst_a: assert property (##1 bufRstN == $past(cfgReg[fmlkd_pkg::CFG_BUF_RN]))
    else $error("buffer reset does not follow its bit");
  bypass_out_a: assert property (##1 modBypass == $past(cfgReg[fmlkd_pkg::CFG_BYPASS]))
    else $error("bypass output does not follow its bit");
  core_seed_a: assert property (coreRunBit && !coreRstN && !fskOn && !softRst
      |=> seedLoad)
    else $error("core release did not load the seed");
  fsk_no_seed_a: assert property (fskOn |=> !seedLoad)
    else $error("seed loaded while FSK enabled");
  seed_route_a: assert property (!fskOn |=> modSeed == $past(seedReg)
      && fskFreq1 == 24'h000000)
    else $error("seed not routed to modulator");
  seed_write_a: assert property (wrSeed |=> seedReg == $past(wrData))
    else $error("seed register write lost");
  fsk_level_a: assert property (fskOn && !senLevel && !softRst |=>
      fskSelect == $past(sdiLevel))
    else $error("FSK select does not follow SDI");
  fsk_hold_a: assert property (fskOn && senLevel && !softRst |=> $stable(fskSelect))
    else $error("FSK select moved during a frame");
  fsk_mode_a: assert property (##1 fskMode == $past(fskOn))
    else $error("FSK mode does not follow its bit");
  csp_mag_a: assert property (##1 cspMagnitude ==
      $past(cfgReg[fmlkd_pkg::CFG_CSP_MAG +: 4]))
    else $error("slip magnitude does not follow its field");
  csp_en_a: assert property (##1 cspEnable == $past(lkdReg[fmlkd_pkg::LKD_CSP_EN]))
    else $error("slip prevention enable does not follow its bit");
  oneshot_sel_a: assert property (##1 ringOscOneshotSel ==
      $past(lkdReg[fmlkd_pkg::LKD_RO_SEL]))
    else $error("one-shot select does not follow its bit");
  oneshot_len_a: assert property (##1 oneshotDuration ==
      $past(lkdReg[fmlkd_pkg::LKD_DUR +: 3]))
    else $error("one-shot length does not follow its field");
  osc_trim_a: assert property (##1 ringOscTrim ==
      $past(lkdReg[fmlkd_pkg::LKD_TRIM +: 2]))
    else $error("oscillator trim does not follow its field");
  lock_out_a: assert property (##1 lockDetected == $past(locked))
    else $error("lock output not one cycle behind lock state");

endmodule

/* verification/frac_modulator_lock_detect_cfg_test.sv */
// Purpose: Self-checking bench for the modulator and lock-detect register bank
// Assumes: Serial frames driven with 4 clk per SCK phase, pins changed 1 ns after clk rise
// Notes: Divider clocks stay static while configuration outputs are compared
`timescale 1ns/1ps

module frac_modulator_lock_detect_cfg_test;
  // Arbitrary identification value
  localparam logic [23:0] ID = 24'h5A3C00;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, srst, senPin, sckPin, sdiPin, lockOrReadbackPin, lockFlagOutputGate;
  logic        refDivClk, vcoDivClk, winLeadHit, winLagHit, seedLoad, fskMode, fskSelect;
  logic        modTypeSel, coreRstN, bufRstN, modBypass, modClk, cspEnable, lockDetected;
  logic        ringOscOneshotSel, ringOscForce;
  logic [23:0] modSeed, fskFreq1, cfgV, sd, seen;
  logic [20:0] lkdV;
  logic [3:0]  cspMagnitude;
  logic [2:0]  oneshotDuration;
  logic [1:0]  ringOscTrim;
  logic [23:0] expQ[$];
  event        got;
  int          errorCnt = 0;
  int          testsRun = 0;
  int          loads = 0;
  int          n;

  fmlkd_top #(.CHIP_ID(ID)) dut
  (
    .clk(clk), .srst(srst), .senPin(senPin), .sckPin(sckPin), .sdiPin(sdiPin),
    .lockOrReadbackPin(lockOrReadbackPin), .lockFlagOutputGate(lockFlagOutputGate),
    .refDivClk(refDivClk), .vcoDivClk(vcoDivClk), .winLeadHit(winLeadHit),
    .winLagHit(winLagHit), .modSeed(modSeed), .fskFreq1(fskFreq1), .seedLoad(seedLoad),
    .fskMode(fskMode), .fskSelect(fskSelect), .modTypeSel(modTypeSel), .coreRstN(coreRstN),
    .bufRstN(bufRstN), .modBypass(modBypass), .modClk(modClk), .cspMagnitude(cspMagnitude),
    .cspEnable(cspEnable), .ringOscOneshotSel(ringOscOneshotSel),
    .oneshotDuration(oneshotDuration), .ringOscTrim(ringOscTrim),
    .ringOscForce(ringOscForce), .lockDetected(lockDetected)
  );

  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
    if (seedLoad === 1'b1)
      loads++;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task summarize();
    if (errorCnt == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input logic [23:0] s, input logic [23:0] e);
    testsRun++;
    if (s !== e)
    begin
      errorCnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // Watcher takes the oldest expectation whenever a result is posted
  initial
    forever
    begin
      @(got);
      check(seen, expQ.pop_front());
    end

  initial
  begin
    #1000000;
    errorCnt++;
    summarize();
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task cmp(input logic [23:0] s, input logic [23:0] e);
    expQ.push_back(e);
    seen = s;
    -> got;
    tick(1);
  endtask

  // Read bits are sampled a full SCK period after their rise, past the sync delay
  task frame(input logic r, input logic [5:0] a, input logic [23:0] d,
             output logic [23:0] q);
    logic [31:0] bits;
    bits = {r, a, d, 1'b0};
    q = 24'h000000;
    senPin = 1;
    for (int j = 0; j < 32; j++)
    begin
      sdiPin = bits[31-j];
      sckPin = 0;
      tick(4);
      if (j >= 8)
        q[31-j] = lockOrReadbackPin;
      sckPin = 1;
      tick(4);
    end
    sckPin = 0;
    tick(4);
    senPin = 0;
    tick(4);
  endtask

  task wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] q;
    frame(1'b0, a, d, q);
  endtask

  task rd(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] q;
    frame(1'b1, a, 24'h000000, q);
    cmp(q, e);
  endtask

  task chkOuts();
    tick(2);
    cmp({6'h00, cspMagnitude, cspEnable, ringOscOneshotSel, oneshotDuration, ringOscTrim,
         ringOscForce, modTypeSel, coreRstN, bufRstN, modBypass, fskMode, modClk},
        {6'h00, cfgV[23:20], lkdV[20], lkdV[13], lkdV[16:14], lkdV[18:17], lkdV[19],
         cfgV[9:8] == 2'h3, cfgV[10], cfgV[11], cfgV[12], cfgV[15],
         cfgV[17] ^ cfgV[18]});
  endtask

  // Window hits are held across the synchronised divider edge
  task vco(input int k, input logic ld, input logic lg);
    repeat (k)
    begin
      winLeadHit = ld;
      winLagHit = lg;
      tick(4);
      vcoDivClk = 1;
      tick(4);
      vcoDivClk = 0;
    end
    tick(8);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(54310));
    srst = 1;
    senPin = 0;
    sckPin = 0;
    sdiPin = 0;
    lockFlagOutputGate = 1;
    refDivClk = 1;
    vcoDivClk = 0;
    winLeadHit = 0;
    winLagHit = 0;
    cfgV = fmlkd_pkg::CFG_RST;
    lkdV = fmlkd_pkg::LKD_RST;
    tick(5);
    srst = 0;
    tick(2);
    rd(fmlkd_pkg::ADDR_SEED, 24'h000000);
    rd(fmlkd_pkg::ADDR_CFG, 24'h842E87);
    rd(fmlkd_pkg::ADDR_LKD, 24'h1004FA);
    rd(fmlkd_pkg::ADDR_ID, ID);
    wr(6'h2A, 24'($urandom));
    rd(6'h2A, 24'h000000);
    chkOuts();
    // Seed, auto-seed and FSK routing
    sd = 24'($urandom);
    wr(fmlkd_pkg::ADDR_SEED, sd);
    tick(2);
    cmp(modSeed, sd);
    cmp(fskFreq1, 24'h000000);
    for (int i = 0; i < 3; i++)
    begin
      cfgV[13] = (i != 1);
      cfgV[15] = (i == 2);
      wr(fmlkd_pkg::ADDR_CFG, cfgV);
      n = loads;
      wr(fmlkd_pkg::ADDR_FRAC, 24'($urandom));
      tick(2);
      cmp(24'(loads - n), (i == 0) ? 24'h000001 : 24'h000000);
    end
    cmp(fskFreq1, sd);
    cmp(modSeed, 24'h000000);
    sdiPin = 1;
    tick(5);
    cmp(fskSelect, 24'h000001);
    sdiPin = 0;
    tick(5);
    cmp(fskSelect, 24'h000000);
    cfgV[15] = 0;
    cfgV[12:10] = 3'b100;
    wr(fmlkd_pkg::ADDR_CFG, cfgV);
    chkOuts();
    n = loads;
    cfgV[12:10] = 3'b011;
    wr(fmlkd_pkg::ADDR_CFG, cfgV);
    chkOuts();
    cmp(24'(loads - n), 24'h000001);
    // Every modulator type code with random fields
    for (int i = 0; i < 4; i++)
    begin
      cfgV = (24'($urandom) & 24'hF6BF00) | (fmlkd_pkg::CFG_RST & ~24'hF6BF00);
      cfgV[9:8] = i[1:0];
      wr(fmlkd_pkg::ADDR_CFG, cfgV);
      rd(fmlkd_pkg::ADDR_CFG, cfgV);
      lkdV = 21'($urandom);
      wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
      rd(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
      chkOuts();
    end
    // Lock detection
    lkdV = 21'h000403;
    wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    vco(2, 1, 0);
    cmp(lockDetected, 24'h000000);
    vco(1, 0, 1);
    cmp(lockDetected, 24'h000001);
    cmp(lockOrReadbackPin, 24'h000001);
    lockFlagOutputGate = 0;
    tick(3);
    cmp(lockOrReadbackPin, 24'h000000);
    lockFlagOutputGate = 1;
    vco(1, 0, 0);
    cmp(lockDetected, 24'h000000);
    lkdV[12:11] = 2'b11;
    wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    vco(3, 0, 1);
    cmp(lockDetected, 24'h000000);
    vco(3, 1, 0);
    cmp(lockDetected, 24'h000001);
    lkdV[12] = 0;
    wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    vco(1, 1, 0);
    cmp(lockDetected, 24'h000000);
    vco(3, 0, 1);
    cmp(lockDetected, 24'h000001);
    lkdV[10] = 0;
    wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    vco(3, 1, 1);
    cmp(lockDetected, 24'h000000);
    lkdV = 21'h000401;
    wr(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    vco(1, 1, 1);
    cmp(lockDetected, 24'h000001);
    // Soft reset returns everything to defaults
    wr(fmlkd_pkg::ADDR_ID, 24'h000001);
    tick(2);
    cmp(lockDetected, 24'h000000);
    cfgV = fmlkd_pkg::CFG_RST;
    lkdV = fmlkd_pkg::LKD_RST;
    chkOuts();
    rd(fmlkd_pkg::ADDR_SEED, 24'h000000);
    rd(fmlkd_pkg::ADDR_CFG, cfgV);
    rd(fmlkd_pkg::ADDR_LKD, {3'h0, lkdV});
    summarize();
  end
endmodule
